/* verilog/lpmc_regs.svh */
// Register offsets, field positions, reset values and timing counts for the power-mode controller
`ifndef LPMC_REGS_SVH
`define LPMC_REGS_SVH

`define LPMC_ADDR_W 4
`define LPMC_OFS_CTRL 4'h0
`define LPMC_OFS_STAT 4'h1
`define LPMC_OFS_IRQ_STAT 4'h2
`define LPMC_OFS_IRQ_MASK 4'h3

// Control register fields
`define LPMC_CTRL_DEEP 0
`define LPMC_CTRL_STANDBY 1
`define LPMC_CTRL_STOP_LP 2
`define LPMC_CTRL_DET_EN 3
`define LPMC_CTRL_DET_RISE 4
`define LPMC_CTRL_DET_FALL 5
`define LPMC_CTRL_W 6
`define LPMC_CTRL_RST 6'h00

// Interrupt status fields
`define LPMC_IRQ_FALL 0
`define LPMC_IRQ_RISE 1
`define LPMC_IRQ_W 2
`define LPMC_IRQ_MASK_RST 2'h0

// Supervisor reset stretch, in ns, and derived cycles at 50 MHz
`define LPMC_CLK_PERIOD_NS 20
`define LPMC_SUP_HOLD_NS 1000
`define LPMC_SUP_HOLD_CYC ((`LPMC_SUP_HOLD_NS + `LPMC_CLK_PERIOD_NS - 1) / `LPMC_CLK_PERIOD_NS)

`endif

/* verilog/lpmc_pkg.sv */
// Types shared by the power-mode controller
package lpmc_pkg;
    typedef enum logic [2:0] {
        LPMC_RUN,
        LPMC_SLEEP,
        LPMC_STOP,
        LPMC_STANDBY,
        LPMC_RESET
    } lpmc_state_t;

    typedef enum logic [1:0] {
        LPMC_REG_MAIN,
        LPMC_REG_LOWPOWER,
        LPMC_REG_POWERDOWN
    } lpmc_regmode_t;
endpackage : lpmc_pkg

/* verilog/lpmc_ctrl.sv */
// Power-mode sequencer with supply supervision and threshold interrupts
`timescale 1ns/1ps
`include "lpmc_regs.svh"

// How it works
// - Regulator has main, low-power, power-down modes; main while running.
// - Stop mode puts the regulator in low-power mode when the stop low-power bit is set, else main.
// - Standby uses power-down mode; core domain unpowered.
// - Regulator enabled out of any reset; disabled only in standby.
// - Sleep halts only processor clock; any interrupt or event wakes.
// - Stop halts core clocks, PLL and both fast oscillators; state kept.
// - Software picks main or low-power regulation for stop before entry.
// - Any external event line wakes from stop.
// - Standby powers off core domain, PLL and fast oscillators.
// - Standby exits on reset pin, watchdog reset, wakeup pin rise, alarm.
// - Clock, watchdog and their sources never stop in stop or standby.
// - Supervisors always active; hold reset while supply below threshold.
// - Power-on supervisor watches only digital supply.
// - Power-down supervisor watches both supplies; option bit drops analog.
// - Detector compares supply with threshold; interrupts on fall, rise or both.
module lpmc_ctrl
    import lpmc_pkg::*;
#(
    parameter int EVT_LINES = 23,
    parameter int SUP_HOLD = `LPMC_SUP_HOLD_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [`LPMC_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic cpu_sleep_req,
    input wire logic cpu_irq_any,
    input wire logic [EVT_LINES-1:0] external_event_lines,
    input wire logic wakeup_pin,
    input wire logic external_reset_pin_n,
    input wire logic independent_watchdog_rst,
    input wire logic rtc_alarm,
    input wire logic dig_supply_ok,
    input wire logic analog_supply_ok,
    input wire logic analog_monitor_off,
    input wire logic detector_threshold_level,
    output logic core_rst_n,
    output logic cpu_clk_en,
    output logic core_clk_en,
    output logic pll_en,
    output logic internal_fast_oscillator_en,
    output logic external_crystal_oscillator_en,
    output logic sysclk_sel_internal,
    output logic regulator_en,
    output logic main_regulation,
    output logic lowpower_regulation,
    output logic lowspeed_domain_en,
    output logic supply_threshold_detector_en,
    output logic irq
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int NS = EVT_LINES + 10;
    logic [NS-1:0] s1_r;
    logic [NS-1:0] s2_r;
    logic [NS-1:0] raw;
    assign raw = {external_event_lines, cpu_sleep_req, cpu_irq_any, wakeup_pin,
        external_reset_pin_n, independent_watchdog_rst, rtc_alarm, dig_supply_ok,
        analog_supply_ok, analog_monitor_off, detector_threshold_level};
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
        end
    end
    logic y_sleep, y_irq, y_wkp, y_external_reset_pin_n, y_wdg, y_alarm, y_dok, y_aok, y_aoff, y_lvl;
    logic [EVT_LINES-1:0] y_evt;
    assign {y_evt, y_sleep, y_irq, y_wkp, y_external_reset_pin_n, y_wdg, y_alarm, y_dok, y_aok,
        y_aoff, y_lvl} = s2_r;

    logic wkp_d_r;
    logic lvl_d_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wkp_d_r <= 1'h0;
            lvl_d_r <= 1'h0;
        end else begin
            wkp_d_r <= y_wkp;
            lvl_d_r <= y_lvl;
        end
    end
    logic wkp_rise;
    assign wkp_rise = y_wkp && !wkp_d_r;

    // ****************************************
    // Supply supervisors
    // ****************************************
    lpmc_state_t state_r;
    logic supply_bad;
    // Power-on watches digital only; power-down adds analog unless opted out
    assign supply_bad = !y_dok || (!y_aok && !y_aoff);
    logic [15:0] hold_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_r <= 16'h0000;
        end else if (supply_bad || !y_external_reset_pin_n || y_wdg) begin
            hold_r <= 16'h0000;
        end else if (state_r == LPMC_STANDBY) begin
            // Restart the stretch so a standby exit replays the reset sequence
            hold_r <= 16'h0000;
        end else if (hold_r != 16'(SUP_HOLD)) begin
            hold_r <= hold_r + 16'h0001;
        end
    end
    logic sup_release;
    assign sup_release = (hold_r == 16'(SUP_HOLD));

    // ****************************************
    // Register file
    // ****************************************
    logic [`LPMC_CTRL_W-1:0] ctrl_r;
    logic [`LPMC_IRQ_W-1:0] istat_r;
    logic [`LPMC_IRQ_W-1:0] imask_r;
    logic in_reset;
    assign in_reset = (state_r == LPMC_RESET);
    logic wr_ctrl, rd_istat;
    assign wr_ctrl = wr && (addr == `LPMC_OFS_CTRL);
    assign rd_istat = rd && (addr == `LPMC_OFS_IRQ_STAT);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= `LPMC_CTRL_RST;
        end else if (in_reset) begin
            ctrl_r <= `LPMC_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= wdata[`LPMC_CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            imask_r <= `LPMC_IRQ_MASK_RST;
        end else if (in_reset) begin
            imask_r <= `LPMC_IRQ_MASK_RST;
        end else if (wr && addr == `LPMC_OFS_IRQ_MASK) begin
            imask_r <= wdata[`LPMC_IRQ_W-1:0];
        end
    end

    // Threshold detector: level high means supply below threshold
    logic det_on;
    assign det_on = ctrl_r[`LPMC_CTRL_DET_EN];
    logic [`LPMC_IRQ_W-1:0] det_evt;
    assign det_evt[`LPMC_IRQ_FALL] = det_on && ctrl_r[`LPMC_CTRL_DET_FALL] && y_lvl && !lvl_d_r;
    assign det_evt[`LPMC_IRQ_RISE] = det_on && ctrl_r[`LPMC_CTRL_DET_RISE] && !y_lvl && lvl_d_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            istat_r <= '0;
        end else if (in_reset) begin
            istat_r <= '0;
        end else begin
            // New events win over the read clear
            istat_r <= (rd_istat ? '0 : istat_r) | det_evt;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            case (addr)
                `LPMC_OFS_CTRL: rdata <= {26'h0, ctrl_r};
                `LPMC_OFS_STAT: rdata <= {27'h0, y_lvl && det_on, 1'h0, state_r};
                `LPMC_OFS_IRQ_STAT: rdata <= {30'h0, istat_r};
                `LPMC_OFS_IRQ_MASK: rdata <= {30'h0, imask_r};
                default: rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'h0;
        end else begin
            irq <= |(((rd_istat ? '0 : istat_r) | det_evt) & imask_r);
        end
    end

    // ****************************************
    // Power-mode sequencer
    // ****************************************
    logic stop_wake, stby_wake;
    assign stop_wake = |y_evt;
    assign stby_wake = !y_external_reset_pin_n || y_wdg || wkp_rise || y_alarm;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= LPMC_RESET;
        end else if (supply_bad || !y_external_reset_pin_n || y_wdg) begin
            state_r <= LPMC_RESET;
        end else begin
            case (state_r)
                LPMC_RESET: begin
                    if (sup_release) begin
                        state_r <= LPMC_RUN;
                    end
                end
                LPMC_RUN: begin
                    if (y_sleep && !ctrl_r[`LPMC_CTRL_DEEP]) begin
                        state_r <= LPMC_SLEEP;
                    end else if (y_sleep && ctrl_r[`LPMC_CTRL_STANDBY]) begin
                        state_r <= LPMC_STANDBY;
                    end else if (y_sleep) begin
                        state_r <= LPMC_STOP;
                    end
                end
                LPMC_SLEEP: begin
                    if (y_irq || stop_wake) begin
                        state_r <= LPMC_RUN;
                    end
                end
                LPMC_STOP: begin
                    if (stop_wake) begin
                        state_r <= LPMC_RUN;
                    end
                end
                LPMC_STANDBY: begin
                    if (stby_wake) begin
                        state_r <= LPMC_RESET;
                    end
                end
                default: state_r <= LPMC_RESET;
            endcase
        end
    end

    // ****************************************
    // Clock, oscillator and regulator outputs
    // ****************************************
    logic stop_lp_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stop_lp_r <= 1'h0;
        end else if (state_r == LPMC_RUN) begin
            stop_lp_r <= ctrl_r[`LPMC_CTRL_STOP_LP];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_rst_n <= 1'h0;
            cpu_clk_en <= 1'h0;
            core_clk_en <= 1'h0;
            pll_en <= 1'h0;
            internal_fast_oscillator_en <= 1'h1;
            external_crystal_oscillator_en <= 1'h0;
            sysclk_sel_internal <= 1'h1;
            regulator_en <= 1'h1;
            main_regulation <= 1'h1;
            lowpower_regulation <= 1'h0;
            lowspeed_domain_en <= 1'h1;
            supply_threshold_detector_en <= 1'h0;
        end else begin
            core_rst_n <= (state_r != LPMC_RESET) && (state_r != LPMC_STANDBY);
            cpu_clk_en <= (state_r == LPMC_RUN);
            core_clk_en <= (state_r == LPMC_RUN) || (state_r == LPMC_SLEEP);
            // Internal fast oscillator only held on in run, sleep and reset; PLL and crystal always off
            pll_en <= 1'h0;
            internal_fast_oscillator_en <= (state_r != LPMC_STOP) && (state_r != LPMC_STANDBY);
            external_crystal_oscillator_en <= 1'h0;
            sysclk_sel_internal <= 1'h1;
            regulator_en <= (state_r != LPMC_STANDBY);
            main_regulation <= (state_r == LPMC_RUN) || (state_r == LPMC_SLEEP)
                || (state_r == LPMC_RESET) || (state_r == LPMC_STOP && !stop_lp_r);
            lowpower_regulation <= (state_r == LPMC_STOP) && stop_lp_r;
            lowspeed_domain_en <= 1'h1;
            supply_threshold_detector_en <= det_on;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_stby_reg_off: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_STANDBY |=> !regulator_en && !main_regulation)
        else $error("regulator on in standby");
    chk_stop_lp: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_STOP && stop_lp_r |=> lowpower_regulation && !main_regulation)
        else $error("stop not low-power regulation");
    chk_run_main: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_RUN |=> main_regulation && regulator_en)
        else $error("run not main regulation");
    chk_sleep_cpu: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_SLEEP |=> !cpu_clk_en && core_clk_en)
        else $error("sleep gating wrong");
    chk_stop_clks: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_STOP |=> !core_clk_en && !internal_fast_oscillator_en && core_rst_n)
        else $error("stop clocks not halted");
    chk_stop_wake: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_STOP && stop_wake && !supply_bad && y_external_reset_pin_n && !y_wdg
        |=> state_r == LPMC_RUN)
        else $error("stop wakeup missed");
    chk_stby_exit: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_STANDBY && stby_wake |=> state_r == LPMC_RESET)
        else $error("standby exit missed");
    chk_sup_hold: assert property (@(posedge clk) disable iff (!arst_n)
        supply_bad |=> state_r == LPMC_RESET ##1 !core_rst_n)
        else $error("reset not held on bad supply");
    chk_det_off: assert property (@(posedge clk) disable iff (!arst_n)
        !det_on |=> $stable(istat_r) || istat_r == '0)
        else $error("detector event while disabled");
    chk_lowspeed_kept: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 lowspeed_domain_en)
        else $error("low-speed domain stopped");
    chk_reset_reg_on: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_RESET |=> regulator_en && main_regulation && !lowpower_regulation)
        else $error("regulator not on after reset");
    chk_stby_osc_off: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_STANDBY |=> !core_rst_n && !pll_en && !internal_fast_oscillator_en
        && !external_crystal_oscillator_en && !core_clk_en)
        else $error("core domain powered in standby");
    chk_stop_main: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_STOP && !stop_lp_r |=> main_regulation && !lowpower_regulation)
        else $error("stop not main regulation");
    chk_stop_lp_kept: assert property (@(posedge clk) disable iff (!arst_n)
        state_r != LPMC_RUN |=> $stable(stop_lp_r))
        else $error("stop regulation choice changed");
    chk_stop_exit_osc: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_STOP ##1 state_r == LPMC_RUN |=> sysclk_sel_internal
        && !external_crystal_oscillator_en && internal_fast_oscillator_en)
        else $error("stop wakeup not on internal oscillator");
    chk_stby_restart: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_STANDBY && stby_wake |=> state_r == LPMC_RESET && hold_r == 16'h0000
        ##1 ctrl_r == `LPMC_CTRL_RST && imask_r == `LPMC_IRQ_MASK_RST)
        else $error("standby exit skipped reset sequence");
    chk_reset_stretch: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_RESET && !sup_release |=> state_r == LPMC_RESET)
        else $error("reset released before stretch");
    chk_sleep_wake: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_SLEEP && (y_irq || stop_wake) && !supply_bad && y_external_reset_pin_n && !y_wdg
        |=> state_r == LPMC_RUN)
        else $error("sleep wakeup missed");
    chk_stby_stays: assert property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_STANDBY && !stby_wake && !supply_bad |=> state_r == LPMC_STANDBY)
        else $error("standby left without a source");
    chk_det_set_wins: assert property (@(posedge clk) disable iff (!arst_n)
        (|det_evt) && !in_reset |=> (istat_r & $past(det_evt)) == $past(det_evt))
        else $error("detector event lost");
    chk_irq_level: assert property (@(posedge clk) disable iff (!arst_n)
        (|(istat_r & imask_r)) && !rd_istat |=> irq)
        else $error("interrupt not raised");
    chk_det_enable: assert property (@(posedge clk) disable iff (!arst_n)
        det_on |=> supply_threshold_detector_en)
        else $error("detector enable not shown");
    cov_sleep: cover property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_SLEEP ##1 state_r == LPMC_RUN);
    cov_stop: cover property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_STOP ##1 state_r == LPMC_RUN);
    cov_stby: cover property (@(posedge clk) disable iff (!arst_n)
        state_r == LPMC_STANDBY ##1 state_r == LPMC_RESET);
    cov_irq: cover property (@(posedge clk) disable iff (!arst_n) $rose(irq));
    cov_det_rise: cover property (@(posedge clk) disable iff (!arst_n)
        $rose(istat_r[`LPMC_IRQ_RISE]));

endmodule : lpmc_ctrl

/* test/lpmc_far_model.sv */
// Core and supply model facing the power-mode controller
`timescale 1ns/1ps
module lpmc_far_model (
    input wire logic clk,
    input wire logic sleep_cmd,
    input wire logic pwr_on,
    input wire logic ana_drop,
    input wire logic cpu_clk_en,
    output logic cpu_sleep_req,
    output logic analog_supply_ok,
    output logic dig_supply_ok
);
    // ****************
    // Supply ramp and sleep request
    // ****************
    logic [2:0] ramp_r = 3'h0;
    logic req_r = 1'h0;

    // Analog rail first, digital rail four cycles later
    always_ff @(posedge clk) begin
        if (!pwr_on) ramp_r <= 3'h0;
        else if (ramp_r != 3'h4) ramp_r <= ramp_r + 3'h1;
    end
    assign analog_supply_ok = pwr_on && !ana_drop;
    assign dig_supply_ok = pwr_on && ramp_r == 3'h4;

    // Dropped once the processor clock stops, so a wake does not re-enter
    always_ff @(posedge clk) begin
        if (sleep_cmd) req_r <= 1'h1;
        else if (!cpu_clk_en) req_r <= 1'h0;
    end
    assign cpu_sleep_req = req_r;
endmodule : lpmc_far_model

/* test/low_power_mode_controller_bench.sv */
// Self-checking bench for the power-mode controller
`timescale 1ns/1ps
`include "lpmc_regs.svh"
module low_power_mode_controller_bench
    import lpmc_pkg::*;
;
    // ****************
    // Signals, clock and instances
    // ****************
    logic clk = 1'h0, arst_n = 1'h0, wr = 1'h0, rd = 1'h0, cpu_irq_any = 1'h0;
    logic wakeup_pin = 1'h0, external_reset_pin_n = 1'h1, independent_watchdog_rst = 1'h0;
    logic rtc_alarm = 1'h0, analog_monitor_off = 1'h0, detector_threshold_level = 1'h0;
    logic sleep_cmd = 1'h0, pwr_on = 1'h1, ana_drop = 1'h0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [22:0] external_event_lines = 23'h0;
    logic cpu_sleep_req, dig_supply_ok, analog_supply_ok, core_rst_n, cpu_clk_en, core_clk_en;
    logic pll_en, internal_fast_oscillator_en, external_crystal_oscillator_en, sysclk_sel_internal;
    logic regulator_en, main_regulation, lowpower_regulation, lowspeed_domain_en, irq;
    logic supply_threshold_detector_en;
    int err_total = 0, compares = 0;

    initial forever #10 clk = ~clk;

    lpmc_ctrl #(.EVT_LINES(23), .SUP_HOLD(4)) dut (
        .clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .cpu_sleep_req, .cpu_irq_any,
        .external_event_lines, .wakeup_pin, .external_reset_pin_n, .independent_watchdog_rst,
        .rtc_alarm, .dig_supply_ok, .analog_supply_ok, .analog_monitor_off,
        .detector_threshold_level, .core_rst_n, .cpu_clk_en, .core_clk_en, .pll_en,
        .internal_fast_oscillator_en, .external_crystal_oscillator_en, .sysclk_sel_internal,
        .regulator_en, .main_regulation, .lowpower_regulation, .lowspeed_domain_en,
        .supply_threshold_detector_en, .irq
    );
    lpmc_far_model far (
        .clk, .sleep_cmd, .pwr_on, .ana_drop, .cpu_clk_en, .cpu_sleep_req, .analog_supply_ok,
        .dig_supply_ok
    );

    // ****************
    // Tasks and expectations
    // ****************
    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    function automatic logic [31:0] outs();
        return {21'h0, core_rst_n, cpu_clk_en, core_clk_en, regulator_en, main_regulation,
            lowpower_regulation, pll_en, internal_fast_oscillator_en,
            external_crystal_oscillator_en, sysclk_sel_internal, lowspeed_domain_en};
    endfunction : outs

    function automatic logic [31:0] exp_outs(input lpmc_state_t s, input logic lp);
        logic run, stp, sby;
        run = s == LPMC_RUN || s == LPMC_SLEEP;
        stp = s == LPMC_STOP;
        sby = s == LPMC_STANDBY;
        return {21'h0, run | stp, s == LPMC_RUN, run, !sby, !sby && !(stp && lp), stp && lp,
            1'h0, !stp && !sby, 1'h0, 2'h3};
    endfunction : exp_outs

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask : wr_reg

    task automatic chk_rd(input string nm, input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        chk(nm, rdata, exp);
    endtask : chk_rd

    task automatic waitv(input int k, input logic v);
        int n;
        n = 0;
        while ((k == 0 ? cpu_clk_en : core_rst_n) !== v && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("wait", {31'h0, k == 0 ? cpu_clk_en : core_rst_n}, {31'h0, v});
        repeat (2) @(posedge clk);
        #1;
    endtask : waitv

    task automatic enter(input logic [31:0] c);
        wr_reg(`LPMC_OFS_CTRL, c);
        @(posedge clk);
        sleep_cmd <= 1'h1;
        @(posedge clk);
        sleep_cmd <= 1'h0;
        waitv(0, 1'h0);
    endtask : enter

    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: external_reset_pin_n <= 1'h0;
            1: independent_watchdog_rst <= 1'h1;
            2: wakeup_pin <= 1'h1;
            3: rtc_alarm <= 1'h1;
            4: cpu_irq_any <= 1'h1;
            default: external_event_lines <= 23'h1 << ($urandom % 23);
        endcase
        repeat (4) @(posedge clk);
        {wakeup_pin, independent_watchdog_rst, rtc_alarm, cpu_irq_any} <= 4'h0;
        external_reset_pin_n <= 1'h1;
        external_event_lines <= 23'h0;
    endtask : pulse

    task automatic sup(input logic p, input logic a, input logic o);
        @(posedge clk);
        pwr_on <= p;
        ana_drop <= a;
        analog_monitor_off <= o;
    endtask : sup

    task automatic thr(input logic v);
        @(posedge clk);
        detector_threshold_level <= v;
        repeat (8) @(posedge clk);
        #1;
    endtask : thr

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end

    initial begin
        void'($urandom(32'h2890));
        repeat (5) @(posedge clk);
        #1;
        chk("reset outs", outs(), exp_outs(LPMC_RESET, 1'h0));
        @(posedge clk);
        arst_n <= 1'h1;
        waitv(1, 1'h1);
        chk("run outs", outs(), exp_outs(LPMC_RUN, 1'h0));
        chk_rd("ctrl", `LPMC_OFS_CTRL, 32'h0);
        chk_rd("mask", `LPMC_OFS_IRQ_MASK, 32'h0);
        chk_rd("unmapped", 4'hF, 32'h0);
        repeat (3 + $urandom % 3) begin
            enter(32'h0);
            chk("sleep outs", outs(), exp_outs(LPMC_SLEEP, 1'h0));
            chk_rd("sleep st", `LPMC_OFS_STAT, {29'h0, LPMC_SLEEP});
            pulse(4 + $urandom % 2);
            waitv(0, 1'h1);
        end
        for (int lp = 0; lp < 2; lp++) begin
            enter({29'h0, lp[0], 2'h1});
            chk("stop outs", outs(), exp_outs(LPMC_STOP, lp[0]));
            chk("stop slow", {31'h0, lowspeed_domain_en}, 32'h1);
            chk_rd("stop st", `LPMC_OFS_STAT, {29'h0, LPMC_STOP});
            pulse(5);
            waitv(0, 1'h1);
            chk("stop exit", outs(), exp_outs(LPMC_RUN, 1'h0));
        end
        for (int k = 0; k < 4; k++) begin
            enter(32'h3);
            chk("sby outs", outs(), exp_outs(LPMC_STANDBY, 1'h0));
            chk("sby slow", {31'h0, lowspeed_domain_en}, 32'h1);
            pulse(k);
            waitv(1, 1'h1);
            chk_rd("sby ctrl", `LPMC_OFS_CTRL, 32'h0);
        end
        sup(1'h0, 1'h0, 1'h0);
        waitv(1, 1'h0);
        sup(1'h1, 1'h0, 1'h0);
        waitv(1, 1'h1);
        sup(1'h1, 1'h1, 1'h0);
        waitv(1, 1'h0);
        sup(1'h1, 1'h0, 1'h0);
        waitv(1, 1'h1);
        sup(1'h1, 1'h1, 1'h1);
        thr(1'h1);
        chk("ana off", {31'h0, core_rst_n}, 32'h1);
        chk("det idle", {31'h0, supply_threshold_detector_en}, 32'h0);
        chk_rd("idle ist", `LPMC_OFS_IRQ_STAT, 32'h0);
        sup(1'h1, 1'h0, 1'h0);
        thr(1'h0);
        wr_reg(`LPMC_OFS_CTRL, 32'h38);
        wr_reg(`LPMC_OFS_IRQ_MASK, 32'h3);
        thr(1'h1);
        chk("det on", {31'h0, supply_threshold_detector_en}, 32'h1);
        chk("irq fall", {31'h0, irq}, 32'h1);
        chk_rd("below", `LPMC_OFS_STAT, 32'h10);
        chk_rd("fell", `LPMC_OFS_IRQ_STAT, 32'h1);
        chk_rd("cleared", `LPMC_OFS_IRQ_STAT, 32'h0);
        chk("irq low", {31'h0, irq}, 32'h0);
        thr(1'h0);
        chk_rd("rose", `LPMC_OFS_IRQ_STAT, 32'h2);
        wr_reg(`LPMC_OFS_CTRL, 32'h18);
        wr_reg(`LPMC_OFS_IRQ_MASK, 32'h0);
        thr(1'h1);
        chk_rd("rise only", `LPMC_OFS_IRQ_STAT, 32'h0);
        thr(1'h0);
        chk("masked", {31'h0, irq}, 32'h0);
        chk_rd("masked ist", `LPMC_OFS_IRQ_STAT, 32'h2);
        stop_test();
    end
endmodule : low_power_mode_controller_bench
